// ==== core/cp_mmu_map.svh ====
// register numbers, control bits, reset values and fault codes
`ifndef CP_MMU_MAP_SVH
`define CP_MMU_MAP_SVH
`define REG_IDENT 4'h0
`define REG_CONTROL 4'h1
`define REG_TABLE_BASE 4'h2
`define REG_DOMAIN_ACCESS 4'h3
`define REG_FAULT_STATUS 4'h5
`define REG_FAULT_ADDRESS 4'h6
`define REG_CACHE_OPS 4'h7
`define REG_PROCESS_ID 4'hD
`define CP_NUMBER 4'hF
`define CTL_MMU 0
`define CTL_ALIGN 1
`define CTL_DATA_CACHE 2
`define CTL_INSTRUCTION_CACHE 12
`define CTL_ROUND_ROBIN 14
`define CONTROL_RESET 32'h00000078
`define CONTROL_WMASK 32'hC0007387
`define OPS_INV_INSTRUCTION_CACHE 4'h5
`define OPS_INV_DATA_CACHE 4'h6
`define OPS_INV_BOTH 4'h7
`define FLT_ALIGN 4'h1
`define FLT_TRANSLATION 4'h5
`define FLT_DOMAIN 4'h9
`define FLT_PERMISSION 4'hD
`define FLT_EXT_LINE 4'h4
`define FLT_EXT_ACCESS 4'h8
`define FLT_EXT_WALK 4'hC
`define DOM_NONE 2'h0
`define DOM_CLIENT 2'h1
`define DOM_MANAGER 2'h3
`endif

// ==== core/cp_mmu_pkg.sv ====
// shared types of the coprocessor, mmu and cache block
package cp_mmu_pkg;
  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_HALF,
    SIZE_WORD,
    SIZE_RSVD
  } access_size_e;
  typedef logic [3:0] fault_code_t;
endpackage

// ==== core/mmu_access_check.sv ====
// alignment, translation, domain and permission check of one access
`timescale 1ns/1ps
module mmu_access_check #(
  parameter int DOMAINS = 16
) (
  input wire logic mmu_enable,
  input wire logic align_enable,
  input wire logic [1:0] addr_low,
  input wire cp_mmu_pkg::access_size_e size,
  input wire logic xlat_valid,
  input wire logic [3:0] domain,
  input wire logic [2*DOMAINS-1:0] domain_access,
  input wire logic perm_ok,
  output logic fault,
  output cp_mmu_pkg::fault_code_t status
);
  import cp_mmu_pkg::*;
  `include "cp_mmu_map.svh"
  logic misaligned;
  logic [1:0] dom_field;
  initial begin
    if (DOMAINS != 16) $error("domain field is four bits wide");
  end
  always_comb begin
    misaligned = 1'b0;
    case (size)
      SIZE_HALF: misaligned = addr_low[0];
      SIZE_WORD: misaligned = addr_low != 2'h0;
      default: misaligned = 1'b0;
    endcase
  end
  assign dom_field = domain_access[{domain, 1'b0} +: 2];
  // alignment is checked ahead of translation, mmu on or off
  always_comb begin
    fault = 1'b0;
    status = 4'h0;
    if (align_enable && misaligned) begin
      fault = 1'b1;
      status = `FLT_ALIGN;
    end else if (mmu_enable) begin
      if (!xlat_valid) begin
        fault = 1'b1;
        status = `FLT_TRANSLATION;
      end else if (dom_field == `DOM_NONE || dom_field == 2'h2) begin
        // reserved domain setting is refused like no access
        fault = 1'b1;
        status = `FLT_DOMAIN;
      end else if (dom_field == `DOM_CLIENT && !perm_ok) begin
        fault = 1'b1;
        status = `FLT_PERMISSION;
      end
    end
  end
endmodule

// ==== core/cp_mmu_cache.sv ====
// system control coprocessor, mmu fault logic, cache tags, write buffer
`timescale 1ns/1ps
module cp_mmu_cache #(
  parameter int WAYS = 64,
  parameter int SEGMENTS = 8,
  parameter int WB_WORDS = 16,
  parameter int WB_ADDRS = 4,
  parameter logic [3:0] LAYOUT_REVISION = 4'h0,
  parameter logic [11:0] PART_NUMBER = 12'h123, // arbitrary value
  parameter logic [3:0] ARCH_CODE = 4'h0, // arbitrary value
  parameter logic [3:0] SPEC_REVISION = 4'h0, // arbitrary value
  parameter logic [7:0] IMPLEMENTOR = 8'h00, // arbitrary value
  parameter logic [3:0] CACHE_CTYPE = 4'h0,
  parameter logic [11:0] DATA_CACHE_SIZE_WORD = 12'h000,
  parameter logic [11:0] INSTRUCTION_CACHE_SIZE_WORD = 12'h000
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cp_valid,
  input wire logic [31:0] cp_instr,
  input wire logic cp_privileged,
  input wire logic [31:0] cp_wdata,
  output logic cp_done,
  output logic cp_undefined,
  output logic [31:0] cp_rdata,
  input wire logic i_req,
  input wire logic [31:0] i_va,
  input wire logic i_xlat_valid,
  input wire logic [31:0] i_pa,
  input wire logic [3:0] i_domain,
  input wire logic i_perm_ok,
  input wire logic i_cacheable,
  output logic i_ready,
  output logic i_done,
  output logic i_hit,
  output logic i_abort,
  output logic i_bus_req,
  output logic [31:0] i_bus_addr,
  output logic i_bus_line,
  input wire logic i_bus_done,
  input wire logic i_bus_error,
  input wire logic d_req,
  input wire logic d_write,
  input wire cp_mmu_pkg::access_size_e d_size,
  input wire logic [31:0] d_va,
  input wire logic [31:0] d_wdata,
  input wire logic d_xlat_valid,
  input wire logic [31:0] d_pa,
  input wire logic [3:0] d_domain,
  input wire logic d_perm_ok,
  input wire logic d_cacheable,
  input wire logic d_writeback,
  input wire logic walk_abort,
  output logic d_ready,
  output logic d_done,
  output logic d_hit,
  output logic d_abort,
  output logic d_bus_req,
  output logic [31:0] d_bus_addr,
  output logic d_bus_line,
  input wire logic d_bus_done,
  input wire logic d_bus_error,
  output logic evict_req,
  output logic [31:0] evict_addr,
  output logic wb_valid,
  output logic [31:0] wb_addr,
  output logic [31:0] wb_data,
  input wire logic wb_ready
);
  import cp_mmu_pkg::*;
  `include "cp_mmu_map.svh"
  localparam int LINES = WAYS * SEGMENTS;
  localparam int WW = $clog2(WAYS);
  localparam int SW = $clog2(SEGMENTS);
  localparam int LW = $clog2(LINES);
  initial begin
    if (WAYS != 64 || SEGMENTS != 8) $error("cache geometry is fixed");
    if (WB_WORDS != 16 || WB_ADDRS != 4) $error("write buffer is fixed");
  end

  logic [31:0] control_q;
  logic [31:14] table_base_q;
  logic [31:0] domain_access_q;
  logic [7:0] fault_status_q;
  logic [31:0] fault_address_q;
  logic [6:0] process_id_q;
  logic [LINES-1:0] i_valid_q;
  logic [LINES-1:0] d_valid_q;
  logic [LINES-1:0] d_dirty_q;
  logic [23:0] i_tag_q [LINES];
  logic [23:0] d_tag_q [LINES];
  logic [25:0] phys_tag_q [LINES];
  logic [WW-1:0] i_victim_q;
  logic [WW-1:0] d_victim_q;
  logic [15:0] lfsr_q;
  logic i_pend_q;
  logic [LW-1:0] i_fill_line_q;
  logic [23:0] i_fill_tag_q;
  logic d_pend_q;
  logic d_pend_line_q;
  logic [LW-1:0] d_fill_line_q;
  logic [23:0] d_fill_tag_q;
  logic [25:0] d_fill_ptag_q;
  logic [31:0] d_pend_va_q;
  logic [3:0] d_pend_dom_q;

  // coprocessor transfer decode
  logic cp_ours;
  logic cp_xfer;
  logic cp_other;
  logic cp_read;
  logic [3:0] cp_reg;
  logic [3:0] cp_sub;
  logic [2:0] cp_op2;
  logic cp_write_ok;
  logic [31:0] cp_value;
  assign cp_ours = cp_valid && cp_instr[11:8] == `CP_NUMBER;
  assign cp_xfer = cp_instr[27:24] == 4'hE && cp_instr[4];
  assign cp_other = (cp_instr[27:24] == 4'hE && !cp_instr[4])
                    || cp_instr[27:25] == 3'b110;
  assign cp_read = cp_instr[20];
  assign cp_reg = cp_instr[19:16];
  assign cp_sub = cp_instr[3:0];
  assign cp_op2 = cp_instr[7:5];
  // the core register field is not checked; naming the pc is the core's fault
  assign cp_write_ok = cp_ours && cp_xfer && cp_privileged && !cp_read
                       && cp_op2 == 3'h0;

  always_comb begin
    cp_value = 32'h00000000;
    case (cp_reg)
      `REG_IDENT: begin
        if (cp_op2 == 3'h1) begin
          cp_value = {3'h0, CACHE_CTYPE, 1'b1, DATA_CACHE_SIZE_WORD,
                      INSTRUCTION_CACHE_SIZE_WORD};
        end else begin
          cp_value = {IMPLEMENTOR, SPEC_REVISION, ARCH_CODE, PART_NUMBER,
                      LAYOUT_REVISION};
        end
      end
      `REG_CONTROL: cp_value = control_q;
      `REG_TABLE_BASE: cp_value = {table_base_q, 14'h0000};
      `REG_DOMAIN_ACCESS: cp_value = domain_access_q;
      `REG_FAULT_STATUS: cp_value = {24'h000000, fault_status_q};
      `REG_FAULT_ADDRESS: cp_value = fault_address_q;
      `REG_PROCESS_ID: cp_value = {process_id_q, 25'h0000000};
      default: cp_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cp_done <= 1'b0;
      cp_undefined <= 1'b0;
      cp_rdata <= 32'h00000000;
    end else begin
      cp_done <= cp_ours;
      cp_undefined <= cp_ours
                      && (cp_other || !cp_xfer || !cp_privileged);
      if (cp_ours && cp_xfer && cp_privileged && cp_read) begin
        cp_rdata <= (cp_reg == `REG_IDENT || cp_op2 == 3'h0) ? cp_value
                    : 32'h00000000;
      end
    end
  end

  logic cp_wr_control;
  logic cp_wr_fsr;
  logic cp_wr_far;
  logic inv_instruction_cache;
  logic inv_data_cache;
  assign cp_wr_control = cp_write_ok && cp_reg == `REG_CONTROL;
  assign cp_wr_fsr = cp_write_ok && cp_reg == `REG_FAULT_STATUS;
  assign cp_wr_far = cp_write_ok && cp_reg == `REG_FAULT_ADDRESS;
  assign inv_instruction_cache = cp_write_ok && cp_reg == `REG_CACHE_OPS
                      && (cp_sub == `OPS_INV_INSTRUCTION_CACHE
                          || cp_sub == `OPS_INV_BOTH);
  assign inv_data_cache = cp_write_ok && cp_reg == `REG_CACHE_OPS
                      && (cp_sub == `OPS_INV_DATA_CACHE
                          || cp_sub == `OPS_INV_BOTH);

  always_ff @(posedge clock) begin
    if (reset) begin
      control_q <= `CONTROL_RESET;
      table_base_q <= '0;
      domain_access_q <= 32'h00000000;
      process_id_q <= 7'h00;
    end else if (cp_write_ok) begin
      case (cp_reg)
        `REG_CONTROL: control_q <= (cp_wdata & `CONTROL_WMASK)
                                   | `CONTROL_RESET;
        `REG_TABLE_BASE: table_base_q <= cp_wdata[31:14];
        `REG_DOMAIN_ACCESS: domain_access_q <= cp_wdata;
        `REG_PROCESS_ID: process_id_q <= cp_wdata[31:25];
        default: control_q <= control_q;
      endcase
    end
  end

  logic mmu_on;
  logic instruction_cache_on;
  logic data_cache_on;
  assign mmu_on = control_q[`CTL_MMU];
  assign instruction_cache_on = control_q[`CTL_INSTRUCTION_CACHE];
  assign data_cache_on = control_q[`CTL_DATA_CACHE];

  // context id relocates only the lowest 32 MB of virtual space
  function automatic logic [31:0] to_mva(input logic [31:0] va,
                                         input logic [6:0] pid);
    to_mva = (va[31:25] == 7'h00) ? {pid, va[24:0]} : va;
  endfunction
  logic [31:0] i_mva;
  logic [31:0] d_mva;
  assign i_mva = to_mva(i_va, process_id_q);
  assign d_mva = to_mva(d_va, process_id_q);

  logic i_fault;
  fault_code_t i_status;
  logic d_fault;
  fault_code_t d_status;
  mmu_access_check #(.DOMAINS(16)) i_check (
    .mmu_enable(mmu_on),
    .align_enable(1'b0),
    .addr_low(i_mva[1:0]),
    .size(SIZE_WORD),
    .xlat_valid(i_xlat_valid),
    .domain(i_domain),
    .domain_access(domain_access_q),
    .perm_ok(i_perm_ok),
    .fault(i_fault),
    .status(i_status)
  );
  mmu_access_check #(.DOMAINS(16)) d_check (
    .mmu_enable(mmu_on),
    .align_enable(control_q[`CTL_ALIGN]),
    .addr_low(d_mva[1:0]),
    .size(d_size),
    .xlat_valid(d_xlat_valid),
    .domain(d_domain),
    .domain_access(domain_access_q),
    .perm_ok(d_perm_ok),
    .fault(d_fault),
    .status(d_status)
  );

  // parallel tag lookup over all ways of one segment
  logic i_lookup_hit;
  logic d_lookup_hit;
  logic [LW-1:0] d_hit_line;
  always_comb begin
    i_lookup_hit = 1'b0;
    d_lookup_hit = 1'b0;
    d_hit_line = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (i_valid_q[{i_mva[7:5], w[WW-1:0]}]
          && i_tag_q[{i_mva[7:5], w[WW-1:0]}] == i_mva[31:8]) begin
        i_lookup_hit = 1'b1;
      end
      if (d_valid_q[{d_mva[7:5], w[WW-1:0]}]
          && d_tag_q[{d_mva[7:5], w[WW-1:0]}] == d_mva[31:8]) begin
        d_lookup_hit = 1'b1;
        d_hit_line = {d_mva[7:5], w[WW-1:0]};
      end
    end
  end

  logic [31:0] i_phys;
  logic i_take;
  logic i_cache_use;
  assign i_phys = mmu_on ? i_pa : i_mva;
  assign i_ready = !i_pend_q;
  assign i_take = i_req && i_ready;
  assign i_cache_use = instruction_cache_on && (i_cacheable || !mmu_on);

  // instruction fetch: hit, linefill or single bus fetch
  always_ff @(posedge clock) begin
    if (reset) begin
      i_done <= 1'b0;
      i_hit <= 1'b0;
      i_abort <= 1'b0;
      i_bus_req <= 1'b0;
      i_bus_addr <= 32'h00000000;
      i_bus_line <= 1'b0;
      i_pend_q <= 1'b0;
      i_fill_line_q <= '0;
      i_fill_tag_q <= 24'h000000;
    end else begin
      i_done <= 1'b0;
      i_hit <= 1'b0;
      i_abort <= 1'b0;
      i_bus_req <= 1'b0;
      if (i_take && i_fault) begin
        i_done <= 1'b1;
        i_abort <= 1'b1;
      end else if (i_take && i_cache_use && i_lookup_hit) begin
        i_done <= 1'b1;
        i_hit <= 1'b1;
      end else if (i_take) begin
        i_bus_req <= 1'b1;
        i_bus_line <= i_cache_use;
        i_bus_addr <= i_cache_use ? {i_phys[31:5], 5'h00} : i_phys;
        i_fill_line_q <= {i_mva[7:5], i_victim_q};
        i_fill_tag_q <= i_mva[31:8];
        i_pend_q <= 1'b1;
      end else if (i_pend_q && i_bus_done) begin
        i_pend_q <= 1'b0;
        i_done <= 1'b1;
        i_abort <= i_bus_error;
      end
    end
  end

  // replacement: round robin pointer or free-running pseudo random
  always_ff @(posedge clock) begin
    if (reset) begin
      lfsr_q <= 16'hACE1;
      i_victim_q <= '0;
      d_victim_q <= '0;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13]
                 ^ lfsr_q[12] ^ lfsr_q[10]};
      if (i_pend_q && i_bus_done) begin
        i_victim_q <= control_q[`CTL_ROUND_ROBIN] ? i_victim_q + 1'b1
                      : lfsr_q[WW-1:0];
      end
      if (d_pend_q && d_bus_done && d_pend_line_q) begin
        d_victim_q <= control_q[`CTL_ROUND_ROBIN] ? d_victim_q + 1'b1
                      : lfsr_q[WW+1:2];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      i_valid_q <= '0;
    end else begin
      // a fill landing with an invalidate still sets: its data is fresh
      if (inv_instruction_cache) i_valid_q <= '0;
      if (i_pend_q && i_bus_done && i_bus_line && !i_bus_error) begin
        i_valid_q[i_fill_line_q] <= 1'b1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (i_pend_q && i_bus_done && i_bus_line && !i_bus_error) begin
      i_tag_q[i_fill_line_q] <= i_fill_tag_q;
    end
  end

  // data side
  logic wb_full;
  logic d_take;
  logic d_cache_use;
  logic d_store_buf;
  logic [LW-1:0] d_victim_line;
  assign d_ready = !d_pend_q && !wb_full;
  assign d_take = d_req && d_ready;
  assign d_cache_use = data_cache_on && d_cacheable;
  assign d_victim_line = {d_mva[7:5], d_victim_q};
  // write-through hits and all uncached or missing stores use the buffer
  assign d_store_buf = d_take && !d_fault && d_write
                       && !(d_cache_use && d_lookup_hit
                            && d_writeback);

  always_ff @(posedge clock) begin
    if (reset) begin
      d_done <= 1'b0;
      d_hit <= 1'b0;
      d_abort <= 1'b0;
      d_bus_req <= 1'b0;
      d_bus_addr <= 32'h00000000;
      d_bus_line <= 1'b0;
      evict_req <= 1'b0;
      evict_addr <= 32'h00000000;
      d_pend_q <= 1'b0;
      d_pend_line_q <= 1'b0;
      d_fill_line_q <= '0;
      d_fill_tag_q <= 24'h000000;
      d_fill_ptag_q <= 26'h0000000;
      d_pend_va_q <= 32'h00000000;
      d_pend_dom_q <= 4'h0;
    end else begin
      d_done <= 1'b0;
      d_hit <= 1'b0;
      d_abort <= 1'b0;
      d_bus_req <= 1'b0;
      evict_req <= 1'b0;
      if (d_take && (d_fault || walk_abort)) begin
        d_done <= 1'b1;
        d_abort <= 1'b1;
      end else if (d_take && (d_write || (d_cache_use && d_lookup_hit))) begin
        d_done <= 1'b1;
        d_hit <= d_cache_use && d_lookup_hit;
      end else if (d_take) begin
        d_bus_req <= 1'b1;
        d_bus_line <= d_cache_use;
        d_bus_addr <= d_cache_use ? {d_pa[31:5], 5'h00} : d_pa;
        d_pend_q <= 1'b1;
        d_pend_line_q <= d_cache_use;
        d_fill_line_q <= d_victim_line;
        d_fill_tag_q <= d_mva[31:8];
        d_fill_ptag_q <= d_pa[31:6];
        d_pend_va_q <= d_mva;
        d_pend_dom_q <= d_domain;
        if (d_cache_use && d_valid_q[d_victim_line]
            && d_dirty_q[d_victim_line]) begin
          evict_req <= 1'b1;
          evict_addr <= {phys_tag_q[d_victim_line], d_mva[5], 5'h00};
        end
      end else if (d_pend_q && d_bus_done) begin
        d_pend_q <= 1'b0;
        d_done <= 1'b1;
        d_abort <= d_bus_error;
      end
    end
  end

  logic d_fill_ok;
  assign d_fill_ok = d_pend_q && d_bus_done && d_pend_line_q && !d_bus_error;
  always_ff @(posedge clock) begin
    if (reset) begin
      d_valid_q <= '0;
      d_dirty_q <= '0;
    end else begin
      if (inv_data_cache) begin
        d_valid_q <= '0;
        d_dirty_q <= '0;
      end
      if (d_fill_ok) begin
        d_valid_q[d_fill_line_q] <= 1'b1;
        d_dirty_q[d_fill_line_q] <= 1'b0;
      end
      if (d_take && !d_fault && !walk_abort && d_write && d_cache_use
          && d_lookup_hit && d_writeback) begin
        d_dirty_q[d_hit_line] <= 1'b1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (d_fill_ok) begin
      d_tag_q[d_fill_line_q] <= d_fill_tag_q;
      phys_tag_q[d_fill_line_q] <= d_fill_ptag_q;
    end
  end

  // fault records: hardware capture wins over a software write
  always_ff @(posedge clock) begin
    if (reset) begin
      fault_status_q <= 8'h00;
      fault_address_q <= 32'h00000000;
    end else if (d_take && (d_fault || walk_abort)) begin
      fault_status_q <= {d_domain, walk_abort && !d_fault ? `FLT_EXT_WALK
                         : d_status};
      fault_address_q <= d_mva;
    end else if (d_pend_q && d_bus_done && d_bus_error) begin
      fault_status_q <= {d_pend_dom_q, d_pend_line_q ? `FLT_EXT_LINE
                         : `FLT_EXT_ACCESS};
      fault_address_q <= d_pend_va_q;
    end else begin
      if (cp_wr_fsr) fault_status_q <= cp_wdata[7:0];
      if (cp_wr_far) fault_address_q <= cp_wdata;
    end
  end

  // write buffer: address slots with up to four consecutive words each
  logic [29:0] wb_slot_addr_q [WB_ADDRS];
  logic [2:0] wb_slot_cnt_q [WB_ADDRS];
  logic [31:0] wb_word_q [WB_WORDS];
  logic [1:0] wb_ahead_q;
  logic [1:0] wb_atail_q;
  logic [2:0] wb_acnt_q;
  logic [3:0] wb_dhead_q;
  logic [3:0] wb_dtail_q;
  logic [4:0] wb_dcnt_q;
  logic [1:0] wb_off_q;
  logic [1:0] wb_last;
  logic wb_merge;
  logic wb_pop_word;
  logic wb_pop_slot;
  assign wb_last = wb_atail_q - 2'h1;
  // the head slot is never merged into, so a draining burst stays fixed
  assign wb_merge = wb_acnt_q > 3'h1 && wb_slot_cnt_q[wb_last] < 3'h4
                    && wb_slot_addr_q[wb_last]
                       + 30'(wb_slot_cnt_q[wb_last]) == d_pa[31:2];
  assign wb_full = wb_dcnt_q == 5'(WB_WORDS)
                   || wb_acnt_q == 3'(WB_ADDRS);
  assign wb_valid = wb_acnt_q != 3'h0;
  assign wb_addr = {wb_slot_addr_q[wb_ahead_q] + 30'(wb_off_q), 2'h0};
  assign wb_data = wb_word_q[wb_dhead_q];
  assign wb_pop_word = wb_valid && wb_ready;
  assign wb_pop_slot = wb_pop_word
                       && 3'(wb_off_q) + 3'h1 == wb_slot_cnt_q[wb_ahead_q];

  always_ff @(posedge clock) begin
    if (reset) begin
      wb_ahead_q <= 2'h0;
      wb_atail_q <= 2'h0;
      wb_acnt_q <= 3'h0;
      wb_dhead_q <= 4'h0;
      wb_dtail_q <= 4'h0;
      wb_dcnt_q <= 5'h00;
      wb_off_q <= 2'h0;
    end else begin
      if (d_store_buf) begin
        wb_word_q[wb_dtail_q] <= d_wdata;
        wb_dtail_q <= wb_dtail_q + 4'h1;
        if (wb_merge) begin
          wb_slot_cnt_q[wb_last] <= wb_slot_cnt_q[wb_last] + 3'h1;
        end else begin
          wb_slot_addr_q[wb_atail_q] <= d_pa[31:2];
          wb_slot_cnt_q[wb_atail_q] <= 3'h1;
          wb_atail_q <= wb_atail_q + 2'h1;
        end
      end
      if (wb_pop_word) begin
        wb_dhead_q <= wb_dhead_q + 4'h1;
        wb_off_q <= wb_pop_slot ? 2'h0 : wb_off_q + 2'h1;
      end
      if (wb_pop_slot) wb_ahead_q <= wb_ahead_q + 2'h1;
      wb_dcnt_q <= wb_dcnt_q + 5'(d_store_buf) - 5'(wb_pop_word);
      wb_acnt_q <= wb_acnt_q + 3'(d_store_buf && !wb_merge)
                   - 3'(wb_pop_slot);
    end
  end
endmodule

// ==== bench/cp_mmu_monitor.sv ====
// checker of the coprocessor and access handshakes
`timescale 1ns/1ps
module cp_mmu_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic cp_valid,
  input wire logic [31:0] cp_instr,
  input wire logic cp_privileged,
  input wire logic cp_done,
  input wire logic cp_undefined,
  input wire logic i_bus_req,
  input wire logic [31:0] i_bus_addr,
  input wire logic i_bus_line,
  input wire logic i_bus_done,
  input wire logic i_done,
  input wire logic d_req,
  input wire logic d_ready,
  input wire logic walk_abort,
  input wire logic d_abort,
  input wire logic d_bus_req,
  input wire logic evict_req
);
  default clocking
    @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence take_s;
    cp_valid && cp_instr[11:8] == 4'hF;
  endsequence
  sequence xfer_s;
    cp_instr[27:24] == 4'hE && cp_instr[4];
  endsequence
  take_done_a: assert property (take_s |=> cp_done)
    else $error("no done after transfer");
  done_cause_a: assert property (cp_done
    |-> $past(cp_valid && cp_instr[11:8] == 4'hF))
    else $error("done without transfer");
  priv_only_a: assert property (take_s ##0 !cp_privileged
    |=> cp_undefined)
    else $error("user access not refused");
  data_op_a: assert property (take_s ##0 !xfer_s |=> cp_undefined)
    else $error("non transfer not refused");
  xfer_ok_a: assert property (take_s ##0 xfer_s ##0 cp_privileged
    |=> !cp_undefined)
    else $error("transfer refused");
  walk_abort_a: assert property (d_req && d_ready && walk_abort
    |=> d_abort && !d_bus_req)
    else $error("walk abort not signalled");
  abort_quiet_a: assert property (d_abort
    |-> !d_bus_req && !evict_req)
    else $error("bus use on abort");
  line_align_a: assert property (i_bus_req && i_bus_line
    |-> i_bus_addr[4:0] == 5'h00)
    else $error("linefill not line aligned");
  fetch_end_a: assert property (i_bus_done |=> i_done)
    else $error("fetch not finished");
endmodule
bind cp_mmu_cache cp_mmu_monitor mon (.*);

// ==== bench/mem_model.sv ====
// memory side model: answers bus reads and drains the write buffer slowly
`timescale 1ns/1ps
module mem_model #(
  parameter int DELAY = 4
) (
  input wire logic clock,
  input wire logic i_bus_req,
  input wire logic d_bus_req,
  output logic i_bus_done = 1'b0,
  output logic d_bus_done = 1'b0,
  output logic wb_ready = 1'b0
);
  int i_cnt = 0;
  int d_cnt = 0;
  logic [1:0] w_cnt = 2'h0;
  // stalling the buffer lets the bench see an entry before it drains
  always @(posedge clock) begin
    i_cnt <= i_bus_req ? DELAY : (i_cnt > 0 ? i_cnt - 1 : 0);
    d_cnt <= d_bus_req ? DELAY : (d_cnt > 0 ? d_cnt - 1 : 0);
    i_bus_done <= (i_cnt == 1);
    d_bus_done <= (d_cnt == 1);
    w_cnt <= w_cnt + 2'h1;
    wb_ready <= (w_cnt == 2'h3);
  end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench of the coprocessor, mmu and cache block
`timescale 1ns/1ps
module testbench;
  import cp_mmu_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cp_valid, cp_privileged, cp_done, cp_undefined, i_req, i_xlat_valid;
  logic i_perm_ok, i_cacheable, i_ready, i_done, i_hit, i_abort, i_bus_req;
  logic i_bus_line, i_bus_done, i_bus_error, d_req, d_write, d_xlat_valid;
  logic d_perm_ok, d_cacheable, d_writeback, walk_abort, d_ready, d_done;
  logic d_hit, d_abort, d_bus_req, d_bus_line, d_bus_done, d_bus_error;
  logic evict_req, wb_valid, wb_ready;
  logic [31:0] cp_instr, cp_wdata, cp_rdata, i_va, i_pa, i_bus_addr, d_va;
  logic [31:0] d_wdata, d_pa, d_bus_addr, evict_addr, wb_addr, wb_data, ba;
  logic [3:0] i_domain, d_domain;
  access_size_e d_size;
  int num_errors = 0;
  int compares = 0;
  cp_mmu_cache DUT (.*);
  mem_model mem (.clock(clock), .i_bus_req(i_bus_req),
    .d_bus_req(d_bus_req), .i_bus_done(i_bus_done),
    .d_bus_done(d_bus_done), .wb_ready(wb_ready));
  always #5 clock = ~clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // core register field is always zero, never the program counter
  function automatic logic [31:0] xf(logic l, logic [3:0] rn, logic [2:0] o2);
    return {8'hEE, 3'h0, l, rn, 4'h0, 4'hF, o2, 1'b1, 4'h0};
  endfunction
  task automatic cp(input logic [31:0] ins, input logic [31:0] wd);
    @(posedge clock) #1;
    cp_instr = ins;
    cp_wdata = wd;
    cp_valid = 1'b1;
    @(posedge clock) #1;
    cp_valid = 1'b0;
    check(cp_done, 32'h1);
  endtask
  // bit 0 of the seen bus address carries the linefill flag
  task automatic fetch(input logic [31:0] va, input logic [31:0] ea);
    ba = 32'hFFFFFFFF;
    @(posedge clock) #1;
    i_va = va;
    i_pa = va;
    i_req = 1'b1;
    @(posedge clock) #1;
    i_req = 1'b0;
    repeat (20) begin
      if (i_bus_req)
        ba = {i_bus_addr[31:1], i_bus_line};
      if (i_done)
        break;
      @(posedge clock) #1;
    end
    check(ba, ea);
    check(i_hit, ea == 32'hFFFFFFFF);
  endtask
  task automatic dacc(input logic w, input logic [31:0] va, input logic wk);
    @(posedge clock) #1;
    d_write = w;
    d_va = va;
    d_pa = va;
    d_wdata = ~va;
    walk_abort = wk;
    d_req = 1'b1;
    @(posedge clock) #1;
    d_req = 1'b0;
    walk_abort = 1'b0;
    repeat (20) begin
      if (d_done)
        break;
      @(posedge clock) #1;
    end
  endtask
  initial begin
    {cp_valid, cp_privileged, i_req, i_xlat_valid, i_perm_ok} = '0;
    {i_cacheable, i_bus_error, d_req, d_write, d_xlat_valid} = '0;
    {d_perm_ok, d_cacheable, d_writeback, walk_abort, d_bus_error} = '0;
    {cp_instr, cp_wdata, i_va, i_pa, d_va, d_wdata, d_pa} = '0;
    i_domain = 4'h0;
    d_domain = 4'h6;
    d_size = SIZE_WORD;
    repeat (16) @(posedge clock);
    #1 reset = 1'b0;
    cp_privileged = 1'b1;
    cp(xf(1, 4'h1, 3'h0), 0);
    check(cp_rdata, 32'h00000078);
    cp(xf(1, 4'h0, 3'h0), 0);
    check(cp_rdata, 32'h00001230);
    cp(xf(1, 4'h0, 3'h1), 0);
    check(cp_rdata, 32'h01000000);
    cp(xf(0, 4'h3, 3'h0), 32'h5555AAAA);
    cp(xf(1, 4'h3, 3'h0), 0);
    check(cp_rdata, 32'h5555AAAA);
    cp(xf(1, 4'h3, 3'h1), 0);
    check(cp_rdata, 32'h0);
    cp(xf(1, 4'h1, 3'h0) & ~32'h10, 0);
    check(cp_undefined, 32'h1);
    cp(32'hEC000F00, 0);
    check(cp_undefined, 32'h1);
    cp_privileged = 1'b0;
    cp(xf(1, 4'h1, 3'h0), 0);
    check(cp_undefined, 32'h1);
    cp_privileged = 1'b1;
    $display("test coprocessor finished");
    fetch(32'h00000444, 32'h00000444);
    fetch(32'h00000444, 32'h00000444);
    cp(xf(0, 4'h1, 3'h0), 32'h00001002);
    fetch(32'h00000444, 32'h00000441);
    fetch(32'h00000448, 32'hFFFFFFFF);
    cp(xf(0, 4'h1, 3'h0), 32'h00000006);
    fetch(32'h00000448, 32'h00000448);
    $display("test fetch finished");
    dacc(0, 32'h00012344, 1);
    check(d_abort, 32'h1);
    cp(xf(1, 4'h5, 3'h0), 0);
    check(cp_rdata[7:0], 32'h6C);
    cp(xf(1, 4'h6, 3'h0), 0);
    check(cp_rdata, 32'h00012344);
    dacc(0, 32'h00000102, 0);
    check(d_abort, 32'h1);
    cp(xf(1, 4'h5, 3'h0), 0);
    check(cp_rdata[3:0], 32'h1);
    dacc(1, 32'h00000200, 0);
    check({d_abort, wb_valid}, 32'h1);
    check(wb_addr, 32'h00000200);
    check(wb_data, ~32'h00000200);
    repeat (12) @(posedge clock);
    #1 check(wb_valid, 32'h0);
    d_cacheable = 1'b1;
    dacc(0, 32'h00000300, 0);
    check(d_bus_addr, 32'h00000300);
    check(d_bus_line, 32'h1);
    dacc(0, 32'h00000304, 0);
    check(d_hit, 32'h1);
    d_writeback = 1'b1;
    dacc(1, 32'h00000308, 0);
    check({d_hit, wb_valid}, 32'h2);
    d_writeback = 1'b0;
    dacc(1, 32'h0000030C, 0);
    check({d_hit, wb_valid}, 32'h3);
    check(wb_addr, 32'h0000030C);
    $display("test data finished");
    end_sim();
  end
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule
